// File: logic/tps_pkg.sv
package tps_pkg;

    // Register map of the thermal supervisor, one 16-bit register per word address.
    localparam logic [7:0] CTRL_OFFSET   = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] STATE_OFFSET  = 8'h08;

    // Control register fields.
    localparam int AUX_EN_LSB     = 0;
    localparam int AUX_EN_WIDTH   = 2;
    localparam int DELAY_EXT_BIT  = 2;
    localparam int THR_RAISE_BIT  = 3;

    // Status register fields; the flag bits are write-one-to-clear.
    localparam int STAGE1_BIT     = 0;
    localparam int AUX_OT_BIT     = 1;
    localparam int PREWARN_BIT    = 2;
    localparam int STAGE2_BIT     = 3;
    localparam int SAFE_BIT       = 4;
    localparam int CAN_FAIL_LSB   = 5;
    localparam int EVT_CNT_LSB    = 8;

    // Reset values.
    localparam logic [1:0] AUX_EN_RESET   = 2'h0;
    localparam logic       DELAY_EXT_RESET = 1'b0;
    localparam logic       THR_RAISE_RESET = 1'b0;

    // Encodings and counts.
    localparam logic [1:0] CAN_FAIL_OT     = 2'h1;
    localparam logic [1:0] CAN_FAIL_NONE   = 2'h0;
    localparam logic [3:0] EVT_CNT_LAST    = 4'hF;
    localparam logic [5:0] EXTEND_LAST     = 6'h3F;
    localparam logic [15:0] RESTART_CYCLES = 16'h0004;
    localparam int unsigned COOLDOWN_CYCLES_DEF = 32'h000F_4240;

    // Raw comparator outputs from the temperature sensors.
    typedef struct packed {
        logic auxOtLow;
        logic auxOtHigh;
        logic canOtLow;
        logic canOtHigh;
        logic mainPrewarn;
        logic mainTsdLow;
        logic mainTsdHigh;
    } tps_sense_t;

    localparam int SENSE_WIDTH = $bits(tps_sense_t);

    // Requests to the device mode controller.
    typedef struct packed {
        logic failSafe;
        logic restart;
        logic normal;
        logic sleepVeto;
    } tps_mode_req_t;

    typedef enum logic [3:0] {
        ST_RUN     = 4'h1,
        ST_HOT     = 4'h2,
        ST_COOL    = 4'h4,
        ST_RESTART = 4'h8
    } tps_state_t;

endpackage

// File: logic/tps_thermal_supervisor.sv
// Functional notes
// - Stage overtemp: switch that stage off, set flag.
// - Stage protection only while that stage is on.
// - Flags clear only by write, condition gone.
// - Aux overtemp: off, enable bits cleared, flag.
// - CAN overtemp: transmitter off, fail field 01.
// - Transmitter returns automatically after overtemp ends.
// - Prewarning sets sticky flag, write clears later.
// - Shutdown threshold: fail-safe mode, stage2 flag.
// - Cool-down wait, then restart, then normal.
// - Stage2 clear only in normal mode, cool.
// - Count every stage2 event, flag set or not.
// - Delay bit and 16 events: safe, 64x wait.
// - Extended wait holds until safe flag cleared.
// - Counter zeroed when stage2 flag or delay cleared.
// - Stage2 during sleep entry goes fail-safe instead.
// - Raise bit selects higher comparator thresholds.
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
module tps_thermal_supervisor #(
    parameter int unsigned COOLDOWN_CYCLES = tps_pkg::COOLDOWN_CYCLES_DEF
) (
    input  wire logic                  clock,
    input  wire logic                  nrst,
    input  wire logic [7:0]            regAddr,
    input  wire logic [15:0]           regWdata,
    input  wire logic                  regWr,
    input  wire logic                  regRd,
    output logic      [15:0]           regRdata,
    input  wire tps_pkg::tps_sense_t   sense,
    input  wire logic                  canEnabled,
    input  wire logic                  inNormalMode,
    input  wire logic                  sleepEntering,
    output logic                       auxSupplyOn,
    output logic                       txDisable,
    output tps_pkg::tps_mode_req_t     modeReq
);

    logic [tps_pkg::SENSE_WIDTH-1:0] syncA_reg;
    logic [tps_pkg::SENSE_WIDTH-1:0] syncB_reg;
    logic [tps_pkg::SENSE_WIDTH-1:0] syncC_reg;
    logic [tps_pkg::SENSE_WIDTH-1:0] filt_reg;
    tps_pkg::tps_sense_t             senseF;

    logic [1:0]          auxEn_reg;
    logic                delayExt_reg;
    logic                thrRaise_reg;
    logic                stage1_reg;
    logic                auxOt_reg;
    logic                prewarn_reg;
    logic                stage2_reg;
    logic                safe_reg;
    logic [1:0]          canFail_reg;
    logic [3:0]          evtCnt_reg;
    logic                mainHotD_reg;
    logic                txDisable_reg;
    logic                normalPulse_reg;
    logic [15:0]         regRdata_reg;
    tps_pkg::tps_state_t state_reg;
    tps_pkg::tps_state_t state_next;
    logic [31:0]         coolCnt_reg;
    logic [5:0]          period_reg;
    logic [15:0]         restartCnt_reg;

    logic        auxHot;
    logic        canHot;
    logic        mainHot;
    logic        prewarnHot;
    logic        auxTrip;
    logic        canTrip;
    logic        tsdEvent;
    logic        wrCtrl;
    logic        wrStatus;
    logic        clrStage1;
    logic        clrAuxOt;
    logic        clrPrewarn;
    logic        clrStage2;
    logic        clrSafe;
    logic        clrCanFail;
    logic        periodDone;
    logic        coolDone;
    logic        restartDone;
    logic [15:0] statusWord;
    logic [15:0] ctrlWord;

    // Comparator outputs are asynchronous to the clock; a change is taken only once the
    // second and third stages agree, which also rejects a single-cycle glitch.
    genvar i;
    generate
        for (i = 0; i < tps_pkg::SENSE_WIDTH; i++)
        begin : g_sync
            always_ff @(posedge clock or negedge nrst)
            begin
                if (!nrst)
                begin
                    syncA_reg[i] <= 1'b0;
                    syncB_reg[i] <= 1'b0;
                    syncC_reg[i] <= 1'b0;
                    filt_reg[i]  <= 1'b0;
                end
                else
                begin
                    syncA_reg[i] <= sense[i];
                    syncB_reg[i] <= syncA_reg[i];
                    syncC_reg[i] <= syncB_reg[i];
                    if (syncB_reg[i] == syncC_reg[i])
                    begin
                        filt_reg[i] <= syncC_reg[i];
                    end
                end
            end
        end
    endgenerate

    assign senseF = filt_reg;

    assign auxHot     = thrRaise_reg ? senseF.auxOtHigh : senseF.auxOtLow;
    assign canHot     = thrRaise_reg ? senseF.canOtHigh : senseF.canOtLow;
    assign mainHot    = thrRaise_reg ? senseF.mainTsdHigh : senseF.mainTsdLow;
    assign prewarnHot = senseF.mainPrewarn;

    // A stage can only trip while it is switched on, whatever the device mode.
    assign auxTrip  = (|auxEn_reg) & auxHot;
    assign canTrip  = canEnabled & canHot;
    assign tsdEvent = mainHot & ~mainHotD_reg;

    assign wrCtrl   = regWr && (regAddr == tps_pkg::CTRL_OFFSET);
    assign wrStatus = regWr && (regAddr == tps_pkg::STATUS_OFFSET);

    // Write-one-to-clear, refused while the matching condition is still present; the safe flag clears on any write of one to its bit.
    assign clrStage1  = wrStatus & regWdata[tps_pkg::STAGE1_BIT] & ~auxHot & ~canHot;
    assign clrAuxOt   = wrStatus & regWdata[tps_pkg::AUX_OT_BIT] & ~auxHot;
    assign clrPrewarn = wrStatus & regWdata[tps_pkg::PREWARN_BIT] & ~prewarnHot;
    assign clrStage2  = wrStatus & regWdata[tps_pkg::STAGE2_BIT] & ~mainHot & inNormalMode;
    assign clrSafe    = wrStatus & regWdata[tps_pkg::SAFE_BIT];
    assign clrCanFail = wrStatus & (|regWdata[tps_pkg::CAN_FAIL_LSB +: 2]) & ~canHot;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            auxEn_reg    <= tps_pkg::AUX_EN_RESET;
            delayExt_reg <= tps_pkg::DELAY_EXT_RESET;
            thrRaise_reg <= tps_pkg::THR_RAISE_RESET;
        end
        else
        begin
            // The trip wins over a software write in the same cycle; turning the supply
            // back on needs a fresh write once the stage has cooled.
            if (auxTrip)
            begin
                auxEn_reg <= tps_pkg::AUX_EN_RESET;
            end
            else if (wrCtrl)
            begin
                auxEn_reg <= regWdata[tps_pkg::AUX_EN_LSB +: tps_pkg::AUX_EN_WIDTH];
            end
            if (wrCtrl)
            begin
                delayExt_reg <= regWdata[tps_pkg::DELAY_EXT_BIT];
                thrRaise_reg <= regWdata[tps_pkg::THR_RAISE_BIT];
            end
        end
    end

    // Hardware set wins over a software clear in every flag below.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            stage1_reg  <= 1'b0;
            auxOt_reg   <= 1'b0;
            canFail_reg <= tps_pkg::CAN_FAIL_NONE;
        end
        else
        begin
            if (auxTrip || canTrip)
            begin
                stage1_reg <= 1'b1;
            end
            else if (clrStage1)
            begin
                stage1_reg <= 1'b0;
            end
            if (auxTrip)
            begin
                auxOt_reg <= 1'b1;
            end
            else if (clrAuxOt)
            begin
                auxOt_reg <= 1'b0;
            end
            if (canTrip)
            begin
                canFail_reg <= tps_pkg::CAN_FAIL_OT;
            end
            else if (clrCanFail)
            begin
                canFail_reg <= tps_pkg::CAN_FAIL_NONE;
            end
        end
    end

    // The transmitter follows the live condition, so it comes back by itself while the
    // transceiver stays in its normal mode as a receiver.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            txDisable_reg <= 1'b0;
        end
        else
        begin
            txDisable_reg <= canTrip;
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            prewarn_reg <= 1'b0;
        end
        else if (prewarnHot)
        begin
            prewarn_reg <= 1'b1;
        end
        else if (clrPrewarn)
        begin
            prewarn_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            mainHotD_reg <= 1'b0;
            stage2_reg   <= 1'b0;
            safe_reg     <= 1'b0;
        end
        else
        begin
            mainHotD_reg <= mainHot;
            if (tsdEvent)
            begin
                stage2_reg <= 1'b1;
            end
            else if (clrStage2)
            begin
                stage2_reg <= 1'b0;
            end
            if (tsdEvent && delayExt_reg && (evtCnt_reg == tps_pkg::EVT_CNT_LAST))
            begin
                safe_reg <= 1'b1;
            end
            else if (clrSafe)
            begin
                safe_reg <= 1'b0;
            end
        end
    end

    // The counter saturates at 15, reached on the fifteenth event; it only runs while the delay
    // extension is enabled, since clearing that bit holds it at zero.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            evtCnt_reg <= 4'h0;
        end
        else if (!delayExt_reg || clrStage2)
        begin
            evtCnt_reg <= 4'h0;
        end
        else if (tsdEvent && (evtCnt_reg != tps_pkg::EVT_CNT_LAST))
        begin
            evtCnt_reg <= evtCnt_reg + 4'h1;
        end
    end

    // An extended wait is 64 normal periods, so no wide multiplied count is needed.
    assign periodDone  = (coolCnt_reg == 32'(COOLDOWN_CYCLES - 1));
    assign coolDone    = periodDone && (!safe_reg || (period_reg == tps_pkg::EXTEND_LAST));
    assign restartDone = (restartCnt_reg == tps_pkg::RESTART_CYCLES - 16'h0001);

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            tps_pkg::ST_RUN:
            begin
                if (mainHot)
                begin
                    state_next = tps_pkg::ST_HOT;
                end
            end
            tps_pkg::ST_HOT:
            begin
                if (!mainHot)
                begin
                    state_next = tps_pkg::ST_COOL;
                end
            end
            tps_pkg::ST_COOL:
            begin
                if (mainHot)
                begin
                    state_next = tps_pkg::ST_HOT;
                end
                else if (coolDone)
                begin
                    state_next = tps_pkg::ST_RESTART;
                end
            end
            tps_pkg::ST_RESTART:
            begin
                if (mainHot)
                begin
                    state_next = tps_pkg::ST_HOT;
                end
                else if (restartDone)
                begin
                    state_next = tps_pkg::ST_RUN;
                end
            end
            default:
            begin
                state_next = tps_pkg::ST_HOT;
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg <= tps_pkg::ST_RUN;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            coolCnt_reg <= 32'h0000_0000;
            period_reg  <= 6'h00;
        end
        else if (state_reg != tps_pkg::ST_COOL)
        begin
            coolCnt_reg <= 32'h0000_0000;
            period_reg  <= 6'h00;
        end
        else if (periodDone)
        begin
            coolCnt_reg <= 32'h0000_0000;
            period_reg  <= period_reg + 6'h01;
        end
        else
        begin
            coolCnt_reg <= coolCnt_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            restartCnt_reg  <= 16'h0000;
            normalPulse_reg <= 1'b0;
        end
        else
        begin
            if (state_reg == tps_pkg::ST_RESTART)
            begin
                restartCnt_reg <= restartCnt_reg + 16'h0001;
            end
            else
            begin
                restartCnt_reg <= 16'h0000;
            end
            normalPulse_reg <= (state_reg == tps_pkg::ST_RESTART) && (state_next == tps_pkg::ST_RUN);
        end
    end

    assign ctrlWord = {12'h000, thrRaise_reg, delayExt_reg, auxEn_reg};
    assign statusWord = {4'h0, evtCnt_reg, 1'b0, canFail_reg, safe_reg,
                         stage2_reg, prewarn_reg, auxOt_reg, stage1_reg};

    // Unmapped addresses read as zero; read data stands only in the cycle after the strobe.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            regRdata_reg <= 16'h0000;
        end
        else if (regRd)
        begin
            unique case (regAddr)
                tps_pkg::CTRL_OFFSET:   regRdata_reg <= ctrlWord;
                tps_pkg::STATUS_OFFSET: regRdata_reg <= statusWord;
                tps_pkg::STATE_OFFSET:  regRdata_reg <= {12'h000, state_reg};
                default:                regRdata_reg <= 16'h0000;
            endcase
        end
        else
        begin
            regRdata_reg <= 16'h0000;
        end
    end

    assign regRdata            = regRdata_reg;
    assign auxSupplyOn         = |auxEn_reg;
    assign txDisable           = txDisable_reg;
    assign modeReq.failSafe    = (state_reg == tps_pkg::ST_HOT) || (state_reg == tps_pkg::ST_COOL);
    assign modeReq.restart     = (state_reg == tps_pkg::ST_RESTART);
    assign modeReq.normal      = normalPulse_reg;
    // Sleep entry is vetoed while the shutdown condition stands; fail-safe wins instead.
    assign modeReq.sleepVeto   = sleepEntering & mainHot;

endmodule

// File: verification/tps_thermal_supervisor_properties.sv
`timescale 1ns/100ps
module tps_thermal_supervisor_properties #(
    parameter int unsigned COOLDOWN_CYCLES = 20
) (
    input wire logic                   clock,
    input wire logic                   nrst,
    input wire logic                   regWr,
    input wire tps_pkg::tps_sense_t    sense,
    input wire logic                   canEnabled,
    input wire logic                   sleepEntering,
    input wire logic                   auxSupplyOn,
    input wire logic                   txDisable,
    input wire tps_pkg::tps_mode_req_t modeReq
);
    logic        mainAll;
    logic        mainNone;
    int unsigned coolCnt_reg;

    // Both thresholds high means hot whatever the raise bit selects.
    assign mainAll  = sense.mainTsdLow && sense.mainTsdHigh;
    assign mainNone = !sense.mainTsdLow && !sense.mainTsdHigh;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            coolCnt_reg <= 0;
        else if (!mainNone)
            coolCnt_reg <= 0;
        else if (coolCnt_reg < 32'h00FF_FFFF)
            coolCnt_reg <= coolCnt_reg + 1;
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    AST_TX_ONLY_WHEN_ON: assert property (!canEnabled |=> !txDisable)
        else $error("transmitter disabled while its stage was off");
    AST_TX_TRIP: assert property ((canEnabled && sense.canOtLow && sense.canOtHigh) [*7] |-> txDisable)
        else $error("transmitter not disabled on overtemperature");
    AST_TX_AUTO_ON: assert property ((!sense.canOtLow && !sense.canOtHigh) [*6] |-> !txDisable)
        else $error("transmitter not restored after cooling");
    AST_AUX_TRIP: assert property ((sense.auxOtLow && sense.auxOtHigh && !regWr) [*7] |-> !auxSupplyOn)
        else $error("aux supply still on while hot");
    AST_FAILSAFE_ON_HOT: assert property (mainAll [*6] |-> modeReq.failSafe)
        else $error("no fail-safe request while main supply hot");
    AST_COOLDOWN_MIN: assert property ($fell(modeReq.failSafe) |-> coolCnt_reg >= COOLDOWN_CYCLES)
        else $error("fail-safe left before the cool-down time");
    AST_RESTART_SEQ: assert property ($rose(modeReq.restart) |->
        modeReq.restart [*4] ##1 (!modeReq.restart && !modeReq.failSafe) ##[0:1] modeReq.normal)
        else $error("restart phase not followed by normal request");
    AST_SLEEP_VETO: assert property (mainAll [*6] ##0 sleepEntering |-> modeReq.sleepVeto)
        else $error("sleep entry not vetoed while hot");
    AST_VETO_ONLY_SLEEP: assert property (!sleepEntering |-> !modeReq.sleepVeto)
        else $error("sleep veto without sleep entry");

    cover property ($rose(modeReq.failSafe));
    cover property (modeReq.normal);
    cover property ($rose(txDisable));
    cover property (modeReq.sleepVeto);
endmodule

// File: verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    localparam int unsigned COOL = 20;
    localparam logic [6:0]  AUX  = 7'h60;
    localparam logic [6:0]  CANL = 7'h10;
    localparam logic [6:0]  CAN  = 7'h18;
    localparam logic [6:0]  PW   = 7'h04;
    localparam logic [6:0]  MAIN = 7'h03;
    localparam logic [6:0]  COLD = 7'h00;
    localparam logic [7:0]  CT   = tps_pkg::CTRL_OFFSET;
    localparam logic [7:0]  ST   = tps_pkg::STATUS_OFFSET;

    logic                   clock;
    logic                   nrst;
    logic [7:0]             regAddr;
    logic [15:0]            regWdata;
    logic                   regWr;
    logic                   regRd;
    logic [15:0]            regRdata;
    tps_pkg::tps_sense_t    sense;
    logic                   canEnabled;
    logic                   inNormalMode;
    logic                   sleepEntering;
    logic                   auxSupplyOn;
    logic                   txDisable;
    tps_pkg::tps_mode_req_t modeReq;
    logic                   rdLate;
    logic [15:0]            expQ[$];
    int                     n_fail;
    int                     n_compared;
    int                     seed;
    int                     cyc;
    logic [1:0]             en;

    tps_thermal_supervisor #(.COOLDOWN_CYCLES(COOL)) dut (
        .clock(clock), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .sense(sense), .canEnabled(canEnabled), .inNormalMode(inNormalMode),
        .sleepEntering(sleepEntering), .auxSupplyOn(auxSupplyOn), .txDisable(txDisable), .modeReq(modeReq)
    );

    always #5 clock = ~clock;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clock);
        regWr <= 1'b0;
    endtask

    // The expected word is queued at the strobe; the monitor pairs it with the answer.
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clock);
        regRd   <= 1'b1;
        regAddr <= a;
        expQ.push_back(e);
        @(posedge clock);
        regRd <= 1'b0;
    endtask

    task automatic setSense(input logic [6:0] v);
        @(posedge clock);
        sense <= tps_pkg::tps_sense_t'(v);
    endtask

    // Sampling on the falling edge keeps pin checks clear of the update edge.
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask

    task automatic shutdown(output int n);
        setSense(MAIN);
        settle(8);
        check(16'(modeReq.failSafe), 16'h0001);
        rd(tps_pkg::STATE_OFFSET, {12'h000, tps_pkg::ST_HOT});
        setSense(COLD);
        n = 0;
        while (modeReq.normal !== 1'b1 && n < 3000)
        begin
            @(negedge clock);
            n++;
        end
    endtask

    always @(posedge clock)
        rdLate <= regRd;

    always @(negedge clock)
        if (rdLate)
            check(regRdata, expQ.pop_front());

    initial
    begin
        repeat (20000) @(posedge clock);
        n_fail++;
        close_out();
    end

    initial
    begin
        clock = 1'b0;
        nrst = 1'b0;
        regAddr = 8'h00;
        regWdata = 16'h0000;
        regWr = 1'b0;
        regRd = 1'b0;
        sense = tps_pkg::tps_sense_t'(COLD);
        canEnabled = 1'b0;
        inNormalMode = 1'b1;
        sleepEntering = 1'b0;
        n_fail = 0;
        n_compared = 0;
        seed = 32'h9011;
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        rd(CT, 16'h0000);
        rd(ST, 16'h0000);
        rd(tps_pkg::STATE_OFFSET, 16'h0001);
        wr(8'h0C, 16'($random(seed)));
        rd(8'h0C, 16'h0000);
        rd(CT, 16'h0000);
        setSense(AUX | CAN);
        settle(8);
        check(16'(txDisable), 16'h0000);
        rd(ST, 16'h0000);
        setSense(COLD);
        en = 2'($random(seed));
        if (en == 2'h0)
            en = 2'h3;
        wr(CT, {14'h0000, en});
        setSense(AUX);
        settle(8);
        check(16'(auxSupplyOn), 16'h0000);
        rd(CT, 16'h0000);
        rd(ST, 16'h0003);
        wr(ST, 16'hFFFF);
        rd(ST, 16'h0003);
        setSense(COLD);
        settle(8);
        rd(ST, 16'h0003);
        wr(ST, 16'h0003);
        rd(ST, 16'h0000);
        wr(CT, {12'h000, 2'b10, en});
        canEnabled <= 1'b1;
        settle(1);
        check(16'(auxSupplyOn), 16'h0001);
        setSense(CANL);
        settle(8);
        check(16'(txDisable), 16'h0000);
        wr(CT, {14'h0000, en});
        setSense(CAN);
        settle(8);
        check(16'(txDisable), 16'h0001);
        check(16'(auxSupplyOn), 16'h0001);
        rd(ST, 16'h0021);
        setSense(COLD);
        settle(8);
        check(16'(txDisable), 16'h0000);
        rd(ST, 16'h0021);
        wr(ST, 16'h0060);
        wr(ST, 16'h0001);
        rd(ST, 16'h0000);
        setSense(PW);
        settle(8);
        wr(ST, 16'h0004);
        rd(ST, 16'h0004);
        setSense(COLD);
        settle(8);
        rd(ST, 16'h0004);
        wr(ST, 16'h0004);
        rd(ST, 16'h0000);
        wr(CT, {12'h000, 2'b01, en});
        inNormalMode <= 1'b0;
        for (int i = 0; i < 15; i++)
        begin
            shutdown(cyc);
            check(16'(cyc >= COOL && cyc <= COOL + 16), 16'h0001);
        end
        rd(ST, 16'h0F08);
        shutdown(cyc);
        rd(ST, 16'h0F18);
        wr(ST, 16'h0008);
        rd(ST, 16'h0F18);
        inNormalMode <= 1'b1;
        wr(ST, 16'h0008);
        rd(ST, 16'h0010);
        shutdown(cyc);
        check(16'(cyc >= 64 * COOL && cyc <= 64 * COOL + 16), 16'h0001);
        rd(ST, 16'h0118);
        wr(ST, 16'h0010);
        shutdown(cyc);
        check(16'(cyc >= COOL && cyc <= COOL + 16), 16'h0001);
        rd(ST, 16'h0208);
        wr(CT, {14'h0000, en});
        rd(ST, 16'h0008);
        setSense(MAIN);
        sleepEntering <= 1'b1;
        settle(8);
        check(16'(modeReq.sleepVeto), 16'h0001);
        check(16'(modeReq.failSafe), 16'h0001);
        setSense(COLD);
        sleepEntering <= 1'b0;
        settle(COOL + 20);
        close_out();
    end
endmodule

bind tps_thermal_supervisor tps_thermal_supervisor_properties #(.COOLDOWN_CYCLES(COOLDOWN_CYCLES)) u_props (
    .clock(clock), .nrst(nrst), .regWr(regWr), .sense(sense), .canEnabled(canEnabled),
    .sleepEntering(sleepEntering), .auxSupplyOn(auxSupplyOn), .txDisable(txDisable), .modeReq(modeReq)
);
